// *** hw/cfg_bank_map.svh ***
// bit positions, masks, reset value and counts of the configuration word bank
`ifndef CFG_BANK_MAP_SVH
`define CFG_BANK_MAP_SVH

// ------------------------------------------------------------
// word values and masks
// ------------------------------------------------------------
`define CFG_DEFAULT     32'h0000_03FF
`define CFG_RSV_MASK    32'h0008_1000
`define CFG_HW_IGN_MASK 32'hFF80_0C00
`define CFG_UPPER_MASK  32'hFF00_0000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_EN_HI       31
`define CFG_EN_LO       29
`define CFG_RNG_HI      28
`define CFG_RNG_LO      26
`define CFG_REF_ON      25
`define CFG_BUF_OFF     24
`define CFG_ILV         23
`define CFG_NAP         22
`define CFG_DONE_MODE   21
`define CFG_DONE_POL    20
`define CFG_VREF        18
`define CFG_READBACK    17
`define CFG_FULL_UPD    16
`define CFG_SLP_HI      15
`define CFG_SLP_LO      13
`define CFG_CLK_SEL     11
`define CFG_CLK_EXP     10
`define CFG_TRIM_HI     9
`define CFG_TRIM_LO     0
`define CFG_UP_LO       24
`define CFG_LOW_HI      23

// ------------------------------------------------------------
// serial access and pin idle levels
// ------------------------------------------------------------
`define SER_LAST        5'h1F
`define SER_STEP        5'h01
`define PIN_IDLE        23'h70_0000

`endif

// *** hw/cfg_bank_pkg.sv ***
// types shared by the configuration word bank modules
`default_nettype none

package cfg_bank_pkg;

  // pins arriving from the host, all asynchronous to mclk
  typedef struct packed {
    logic        wr_n;       // parallel write strobe
    logic        cs_n;       // access select
    logic        sclk;       // serial shift clock
    logic        sdi;        // serial data in
    logic        hw_mode;    // 1 = hardware mode, 0 = software mode
    logic        ser_mode;   // 1 = serial port, 0 = parallel port
    logic        reset_pin;  // master reset, active high
    logic [15:0] par_data;   // parallel data bus
  } pins_t;

  // decoded effective settings for the converter core
  typedef struct packed {
    logic [2:0] pair_enable;
    logic [2:0] range_2x;
    logic       internal_ref_on;
    logic       ref_buffer_off;
    logic       interleaved_start;
    logic       auto_nap;
    logic       done_as_int;
    logic       done_active_low;
    logic       ref_3v;
    logic       full_config_update;
    logic [2:0] pair_sleep;
    logic       ext_conv_clock_sel;
    logic       conv_clock_export;
    logic [9:0] ref_trim_code;
  } config_ctrl_t;

  // parallel write pairing: upper half first, then lower half
  typedef enum logic {PAR_HIGH, PAR_LOW} par_state_t;

endpackage

`default_nettype wire

// *** hw/pin_sync.sv ***
// three-stage synchroniser with agreement filter for asynchronous pins
`default_nettype none
`timescale 1ns/1ps

module pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock, reset, freeze
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  // raw pins and filtered result
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ------------------------------------------------------------
  // one chain per bit
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [2:0] st_r;  // st_r[0] feeds only st_r[1]
      logic       q_r;   // accepted level
      // shift chain, accept once stages two and three agree
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          st_r <= {3{RST[i]}};
          q_r  <= RST[i];
        end else if (ce) begin
          st_r <= {st_r[1:0], d[i]};
          if (st_r[1] == st_r[2]) begin
            q_r <= st_r[2];
          end
        end
      end
      assign q[i] = q_r;
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

// *** hw/serial_port.sv ***
// 32-bit serial shifter: receives a word and shifts a word out per access
`default_nettype none
`timescale 1ns/1ps
`include "cfg_bank_map.svh"

module serial_port (
  // clock, reset, freeze
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // access framing
  input  wire logic        clr,
  input  wire logic        start,
  input  wire logic        shift,
  // data
  input  wire logic        sdi,
  input  wire logic [31:0] load_word,
  output logic      [31:0] rx_word,
  output logic             done,
  output logic             sdo
);

  logic [4:0]  cnt_r;  // falling edges seen in this access
  logic [31:0] tx_r;   // outgoing word, msb first

  // ------------------------------------------------------------
  // edge counter and receive shifter
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r   <= '0;
      rx_word <= '0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= shift && !clr && !start && (cnt_r == `SER_LAST);
      if (clr || start) begin
        cnt_r <= '0;
      end else if (shift) begin
        cnt_r   <= cnt_r + `SER_STEP;
        rx_word <= {rx_word[30:0], sdi};
      end
    end
  end

  // ------------------------------------------------------------
  // transmit shifter, loaded at access start
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_r <= '0;
    end else if (ce) begin
      if (clr) begin
        tx_r <= '0;
      end else if (start) begin
        tx_r <= load_word;
      end else if (shift) begin
        tx_r <= {tx_r[30:0], 1'b0};
      end
    end
  end

  assign sdo = tx_r[31];

endmodule // serial_port

`default_nettype wire

// *** hw/config_word_bank.sv ***
// configuration word bank: storage, write ports, readback and decoded settings
//
// Overview of operation
// - three bits enable pairs C, B, A
// - range bits: clear 4x reference, set 2x
// - internal reference on only when bit set
// - buffer bit active low, set turns buffers off
// - interleaved start bit, host also sets ext clock
// - auto nap enabled when its bit set
// - done pin busy when clear, interrupt when set
// - done pin active high clear, low set
// - reserved bits always kept and read zero
// - reference level 2.5 V clear, 3 V set
// - readback bit sends word on next access
// - serial: upper eight only unless full update
// - sleep bits power down pairs, host clears enable
// - clock select: internal clear, external set
// - export bit puts conversion clock on pin
// - ten-bit trim code in low bits, resets ones
// - hardware mode ignores listed software-only bits
// - apply at write rise or 32nd falling edge
// - reset loads default, aborts, channels sample
// - writes only in software mode, contents kept
`default_nettype none
`timescale 1ns/1ps
`include "cfg_bank_map.svh"

module config_word_bank (
  // clock, reset, freeze
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // host pins, asynchronous
  input  wire cfg_bank_pkg::pins_t       pins,
  // converter core, same clock
  input  wire logic [31:0]               result_word,
  input  wire logic                      conv_busy,
  input  wire logic                      conv_int,
  input  wire logic                      conv_clk_int,
  // device output pins
  output logic                           serial_out_line,
  output logic                           done_pin,
  output logic                           clk_pin_o,
  output logic                           clk_pin_oe,
  // settings and reset effects toward the core
  output cfg_bank_pkg::config_ctrl_t     ctrl,
  output logic [31:0]                    config_word,
  output logic                           abort_conv,
  output logic                           sample_all
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  cfg_bank_pkg::pins_t        ps;          // filtered pins
  cfg_bank_pkg::par_state_t   par_st_r;    // parallel half pointer
  cfg_bank_pkg::config_ctrl_t ctrl_nxt;    // decoded settings
  logic [31:0] cfg_r;                      // the stored word
  logic [31:0] cfg_nxt;                    // next stored word
  logic [31:0] eff;                        // word as seen in current mode
  logic [31:0] load_word;                  // word to shift out
  logic [31:0] rx_word;                    // word shifted in
  logic [15:0] hi_r;                       // held upper half
  logic        wr_q;                       // strobe one cycle ago
  logic        sclk_q;                     // shift clock one cycle ago
  logic        cs_q;                       // select one cycle ago
  logic        rst_q;                      // reset pin one cycle ago
  logic        wr_rise;                    // strobe rising edge
  logic        sclk_fall;                  // shift clock falling edge
  logic        cs_fall;                    // access start
  logic        par_hit;                    // accepted parallel strobe
  logic        par_apply;                  // second half: commit
  logic        ser_start;                  // serial access begins
  logic        ser_shift;                  // serial bit boundary
  logic        ser_done;                   // 32nd falling edge seen
  logic        ser_apply;                  // serial commit
  logic        sw_mode;                    // software mode level
  logic        rst_s;                      // master reset level
  logic        done_src;                   // selected core event

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  pin_sync #(
    .W   ($bits(cfg_bank_pkg::pins_t)),
    .RST (`PIN_IDLE)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      (pins),
    .q      (ps)
  );

  // ------------------------------------------------------------
  // edge detection on filtered pins
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q   <= 1'b1;
      sclk_q <= 1'b1;
      cs_q   <= 1'b1;
      rst_q  <= 1'b0;
    end else if (ce) begin
      wr_q   <= ps.wr_n;
      sclk_q <= ps.sclk;
      cs_q   <= ps.cs_n;
      rst_q  <= ps.reset_pin;
    end
  end

  assign rst_s     = ps.reset_pin;
  assign sw_mode   = !ps.hw_mode;
  assign wr_rise   = ps.wr_n && !wr_q;
  assign sclk_fall = !ps.sclk && sclk_q;
  assign cs_fall   = !ps.cs_n && cs_q;
  // parallel strobe only counts in software mode on the parallel port
  assign par_hit   = wr_rise && !ps.cs_n && !ps.ser_mode && sw_mode && !rst_s;
  assign par_apply = par_hit && (par_st_r == cfg_bank_pkg::PAR_LOW);
  assign ser_start = cs_fall && ps.ser_mode;
  assign ser_shift = sclk_fall && !ps.cs_n && ps.ser_mode;
  assign ser_apply = ser_done && sw_mode && !rst_s;

  // ------------------------------------------------------------
  // parallel half pairing
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      par_st_r <= cfg_bank_pkg::PAR_HIGH;
      hi_r     <= '0;
    end else if (ce) begin
      if (rst_s || ps.cs_n) begin
        // deselect or reset drops a half-written word
        par_st_r <= cfg_bank_pkg::PAR_HIGH;
      end else if (par_hit) begin
        unique case (par_st_r)
          cfg_bank_pkg::PAR_HIGH: begin
            hi_r     <= ps.par_data;
            par_st_r <= cfg_bank_pkg::PAR_LOW;
          end
          cfg_bank_pkg::PAR_LOW: begin
            par_st_r <= cfg_bank_pkg::PAR_HIGH;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------
  // readback bit picks the stored word instead of results
  assign load_word = cfg_r[`CFG_READBACK] ? cfg_r : result_word;

  serial_port u_ser (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .ce        (ce),
    .clr       (rst_s),
    .start     (ser_start),
    .shift     (ser_shift),
    .sdi       (ps.sdi),
    .load_word (load_word),
    .rx_word   (rx_word),
    .done      (ser_done),
    .sdo       (serial_out_line)
  );

  // ------------------------------------------------------------
  // next stored word
  // ------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    if (par_apply) begin
      // parallel commit at the strobe rise
      cfg_nxt = {hi_r, ps.par_data};
    end else if (ser_apply) begin
      if (rx_word[`CFG_FULL_UPD]) begin
        // full update: whole word
        cfg_nxt = rx_word;
      end else begin
        // partial update: upper eight bits only
        cfg_nxt = (rx_word & `CFG_UPPER_MASK) | (cfg_r & ~`CFG_UPPER_MASK);
      end
    end
    // reserved positions never hold a one
    cfg_nxt = cfg_nxt & ~`CFG_RSV_MASK;
  end

  // ------------------------------------------------------------
  // stored word
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= `CFG_DEFAULT;
    end else if (ce) begin
      if (rst_s) begin
        cfg_r <= `CFG_DEFAULT;
      end else begin
        cfg_r <= cfg_nxt;
      end
    end
  end

  assign config_word = cfg_r;

  // ------------------------------------------------------------
  // effective word: hardware mode masks software-only fields
  // ------------------------------------------------------------
  assign eff = ps.hw_mode ? (cfg_r & ~`CFG_HW_IGN_MASK) : cfg_r;

  // ------------------------------------------------------------
  // decode of fields
  // ------------------------------------------------------------
  always_comb begin
    ctrl_nxt.pair_enable        = eff[`CFG_EN_HI:`CFG_EN_LO];
    ctrl_nxt.range_2x           = eff[`CFG_RNG_HI:`CFG_RNG_LO];
    ctrl_nxt.internal_ref_on    = eff[`CFG_REF_ON];
    ctrl_nxt.ref_buffer_off     = eff[`CFG_BUF_OFF];
    ctrl_nxt.interleaved_start  = eff[`CFG_ILV];
    ctrl_nxt.auto_nap           = eff[`CFG_NAP];
    ctrl_nxt.done_as_int        = eff[`CFG_DONE_MODE];
    ctrl_nxt.done_active_low    = eff[`CFG_DONE_POL];
    ctrl_nxt.ref_3v             = eff[`CFG_VREF];
    ctrl_nxt.full_config_update = eff[`CFG_FULL_UPD];
    ctrl_nxt.pair_sleep         = eff[`CFG_SLP_HI:`CFG_SLP_LO];
    ctrl_nxt.ext_conv_clock_sel = eff[`CFG_CLK_SEL];
    ctrl_nxt.conv_clock_export  = eff[`CFG_CLK_EXP];
    ctrl_nxt.ref_trim_code      = eff[`CFG_TRIM_HI:`CFG_TRIM_LO];
  end

  // registered settings toward the core
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // decoded default word: trim code all ones, every other setting zero
      ctrl <= '{ref_trim_code: '1, default: '0};
    end else if (ce) begin
      ctrl <= ctrl_nxt;
    end
  end

  // ------------------------------------------------------------
  // shared done pin: mode and polarity
  // ------------------------------------------------------------
  assign done_src = cfg_r[`CFG_DONE_MODE] ? conv_int : conv_busy;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done_pin <= 1'b0;
    end else if (ce) begin
      done_pin <= done_src ^ cfg_r[`CFG_DONE_POL];
    end
  end

  // ------------------------------------------------------------
  // conversion clock export on the shared clock pin
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_pin_o  <= 1'b0;
      clk_pin_oe <= 1'b0;
    end else if (ce) begin
      clk_pin_o  <= conv_clk_int;
      clk_pin_oe <= eff[`CFG_CLK_EXP];
    end
  end

  // ------------------------------------------------------------
  // master reset effects on the core
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      abort_conv <= 1'b1;
      sample_all <= 1'b1;
    end else if (ce) begin
      abort_conv <= rst_s && !rst_q;
      sample_all <= rst_s;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n || !ce);

  a_reset_default: assert property (
    rst_s |=> (cfg_r == `CFG_DEFAULT) && sample_all
  ) else $error("reset did not load default word");

  a_hw_freeze_word: assert property (
    (ps.hw_mode && !rst_s) |=> (cfg_r == $past(cfg_r))
  ) else $error("word changed in hardware mode");

  a_reserved_zero: assert property (
    (cfg_r & `CFG_RSV_MASK) == 32'h0000_0000
  ) else $error("reserved bit set");

  a_par_commit: assert property (
    (par_apply && !rst_s) |=> cfg_r == ($past({hi_r, ps.par_data}) & ~`CFG_RSV_MASK)
  ) else $error("parallel write not applied");

  a_ser_partial: assert property (
    (ser_apply && !rx_word[`CFG_FULL_UPD])
      |=> (cfg_r[`CFG_LOW_HI:0] == $past(cfg_r[`CFG_LOW_HI:0]))
          && (cfg_r[31:`CFG_UP_LO] == $past(rx_word[31:`CFG_UP_LO]))
  ) else $error("partial serial update wrong");

  a_ser_full: assert property (
    (ser_apply && rx_word[`CFG_FULL_UPD]) |=> cfg_r == ($past(rx_word) & ~`CFG_RSV_MASK)
  ) else $error("full serial update wrong");

  a_hw_ignore_bits: assert property (
    ps.hw_mode ##1 ps.hw_mode |=> (ctrl.pair_enable == 3'h0) && !ctrl.ext_conv_clock_sel
      && !ctrl.interleaved_start && !clk_pin_oe
  ) else $error("software-only field active in hardware mode");

  a_sw_pair_enable: assert property (
    !ps.hw_mode |=> ctrl.pair_enable == $past(cfg_r[`CFG_EN_HI:`CFG_EN_LO])
  ) else $error("pair enables not following word");

  a_done_polarity: assert property (
    1'b1 |=> done_pin == (($past(cfg_r[`CFG_DONE_MODE]) ? $past(conv_int) : $past(conv_busy))
                          ^ $past(cfg_r[`CFG_DONE_POL]))
  ) else $error("done pin mode or polarity wrong");

  a_readback_word: assert property (
    (ser_start && !rst_s) |=> serial_out_line == $past(load_word[31])
  ) else $error("readback word not loaded");

  c_par_write:  cover property (par_apply);
  c_ser_full:   cover property (ser_apply && rx_word[`CFG_FULL_UPD]);
  c_readback:   cover property (ser_start && cfg_r[`CFG_READBACK]);
  c_pin_reset:  cover property (rst_s && !rst_q);

endmodule // config_word_bank

`default_nettype wire

// *** dv/host_model.sv ***
// host side model: drives the access pins of the configuration word bank
`default_nettype none
`timescale 1ns/1ps
`include "cfg_bank_map.svh"

module host_model (
  // clock and returned serial data
  input  wire logic               mclk,
  input  wire logic               so,
  // pins toward the bank
  output var cfg_bank_pkg::pins_t pins
);
  // ------------------------------------------------------------
  // idle levels and access tasks
  // ------------------------------------------------------------
  initial pins = '{wr_n: 1'b1, cs_n: 1'b1, sclk: 1'b1, default: '0};

  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // host-side legality of a word before sending it
  function automatic logic [31:0] legal(input logic [31:0] w);
    logic [31:0] v;
    v = w & ~`CFG_RSV_MASK;          // reserved bits sent as zero
    if (v[23]) v[11] = 1'b1;         // interleaved start needs ext clock
    v[31:29] = v[31:29] & ~v[15:13]; // sleeping pair left disabled
    return v;
  endfunction

  // one strobe, data turned over once released
  task automatic strobe(input logic [15:0] d);
    pins.par_data <= d;
    pins.wr_n     <= 1'b0;
    hold(4);
    pins.wr_n     <= 1'b1;
    hold(4);
    pins.par_data <= ~d;
    // let the turned-over data stand one edge before the next strobe
    hold(1);
  endtask

  // upper half then lower half in one select period
  task automatic par_write(input logic [31:0] w);
    logic [31:0] v;
    v = legal(w);
    @(posedge mclk);
    pins.ser_mode <= 1'b0;
    pins.cs_n     <= 1'b0;
    hold(4);
    strobe(v[31:16]);
    strobe(v[15:0]);
    pins.cs_n <= 1'b1;
    hold(8);
  endtask

  // 32-bit serial access, msb first, captures the outgoing word
  task automatic ser_access(input logic [31:0] w, output logic [31:0] rd);
    logic [31:0] v;
    v = legal(w);
    @(posedge mclk);
    pins.ser_mode <= 1'b1;
    hold(4);
    pins.cs_n <= 1'b0;
    hold(8);
    for (int i = 31; i >= 0; i--) begin
      pins.sdi <= v[i];
      hold(4);
      rd[i] = so;
      pins.sclk <= 1'b0;
      hold(4);
      pins.sclk <= 1'b1;
    end
    pins.sdi <= ~v[0];
    hold(8);
    pins.cs_n <= 1'b1;
    hold(8);
  endtask

  // mode and reset pin levels
  task automatic set_lvl(input logic hw, input logic rst);
    @(posedge mclk);
    pins.hw_mode   <= hw;
    pins.reset_pin <= rst;
  endtask
endmodule // host_model

`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking testbench of the configuration word bank
`default_nettype none
`timescale 1ns/1ps
`include "cfg_bank_map.svh"

module tb_top;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                       mclk, arst_n, busy, intr, cclk;
  logic [31:0]                res, cw, rd;
  cfg_bank_pkg::pins_t        pins;
  cfg_bank_pkg::config_ctrl_t ctrl;
  logic                       so, done_pin, ck_o, ck_oe, abort, samp;
  int                         fail_count, total_checks, n;
  localparam logic [31:0] W1 = 32'hFFF6_0EAA, W2 = 32'h0015_E155, W3 = 32'h1A00_0000;

  host_model host (.mclk(mclk), .so(so), .pins(pins));
  config_word_bank dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .pins(pins), .result_word(res),
    .conv_busy(busy), .conv_int(intr), .conv_clk_int(cclk), .serial_out_line(so), .done_pin(done_pin),
    .clk_pin_o(ck_o), .clk_pin_oe(ck_oe), .ctrl(ctrl), .config_word(cw), .abort_conv(abort),
    .sample_all(samp));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // effective settings, software-only bits cleared in hardware mode
  function automatic logic [31:0] eff(input logic [31:0] w, input logic hw);
    logic [31:0] m;
    m = hw ? (w & ~`CFG_HW_IGN_MASK) : w;
    return {3'h0, m[31:20], m[18], m[16:13], m[11:0]};
  endfunction

  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk(cw, 32'h0000_03FF);
    chk({3'h0, ctrl}, eff(32'h0000_03FF, 1'b0));
    chk({done_pin, ck_oe, ck_o}, 3'b000);
    $display("test reset done");
  endtask

  task automatic t_par();
    host.par_write(W1);
    settle();
    chk(cw, W1);
    chk({3'h0, ctrl}, eff(W1, 1'b0));
    cclk <= 1'b1;
    intr <= 1'b1;
    settle();
    chk({ck_oe, ck_o, done_pin}, 3'b110);
    intr <= 1'b0;
    settle();
    chk(done_pin, 1'b1);
    $display("test parallel done");
  endtask

  task automatic t_hw();
    host.set_lvl(1'b1, 1'b0);
    settle();
    chk({3'h0, ctrl}, eff(W1, 1'b1));
    chk(ck_oe, 1'b0);
    host.par_write(W2);
    settle();
    chk(cw, W1);
    host.set_lvl(1'b0, 1'b0);
    $display("test hardware mode done");
  endtask

  task automatic t_ser();
    host.ser_access(W2, rd);
    settle();
    chk(rd, W1);
    chk(cw, W2);
    chk({3'h0, ctrl}, eff(W2, 1'b0));
    busy <= 1'b1;
    settle();
    chk(done_pin, 1'b0);
    host.ser_access(W3, rd);
    settle();
    chk(rd, res);
    chk(cw, {W3[31:24], W2[23:0]});
    $display("test serial done");
  endtask

  task automatic t_pin_rst();
    host.set_lvl(1'b0, 1'b1);
    n = 0;
    repeat (12) begin
      @(posedge mclk);
      #1 n += abort;
    end
    chk(n, 1);
    chk(samp, 1'b1);
    chk(cw, 32'h0000_03FF);
    host.set_lvl(1'b0, 1'b0);
    settle();
    chk(samp, 1'b0);
    $display("test pin reset done");
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (8000) @(posedge mclk);
    fail_count++;
    close_out();
  end

  initial begin
    {arst_n, busy, intr, cclk} = '0;
    res = 32'hC3A5_0F69;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    settle();
    t_reset();
    t_par();
    t_hw();
    t_ser();
    t_pin_rst();
    close_out();
  end
endmodule // tb_top

`default_nettype wire
